/* dss_direct_port.sv */
// bridges buffer data bus onto microcontroller bus for port 70h
module dss_direct_port
(
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire dss_pkg::dss_access_t acc,
   input  wire logic                autoIncEnable,
   input  wire logic                outputEnableDisable,
   input  wire logic [7:0]          bufDataIn,
   input  wire logic [15:0]         pointerIn,
   output logic                     portHit,
   output logic                     pointerStep,
   output logic [7:0]               bufDataOut,
   output logic                     bufDataOe,
   output logic                     bufWrite,
   output logic                     bufRead,
   output logic                     buffer_output_enable_n,
   output logic [15:0]              bufAddr,
   output logic                     latchLoad
);

   // ***********************************************
   // decode and bus steering
   // ***********************************************
   always_comb
   begin
      portHit   = (acc.addr == dss_pkg::OFS_DIRECT_PORT);
      bufAddr   = pointerIn;
      bufWrite  = portHit && acc.wr;
      bufRead   = portHit && acc.rd;
      bufDataOut = acc.wdata;
      bufDataOe = bufWrite;
      // switch read keeps memory quiet
      buffer_output_enable_n = !(bufRead && !outputEnableDisable);
      latchLoad = bufRead;
      pointerStep = (bufRead || bufWrite) && autoIncEnable;
   end

endmodule : dss_direct_port

/* dss_mcu_model.sv */
// microcontroller side of the register bus, held until the taking edge
module dss_mcu_model
(
   input  wire logic                 clk_sys,
   input  wire logic [7:0]           rdata,
   input  wire logic                 rdataValid,
   output dss_pkg::dss_access_t      acc
);
   timeunit 1ns;
   timeprecision 100ps;

   initial acc = '0;

   // one write, then an idle cycle so back-to-back calls never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys);
      #1 acc = '0;
      @(posedge clk_sys);
      #1;
   endtask : wr

   // one read, data and valid taken the cycle after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      acc = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      #1 acc = '0;
      d = rdata;
      v = rdataValid;
      @(posedge clk_sys);
      #1;
   endtask : rd
endmodule : dss_mcu_model

/* dss_pkg.sv */
package dss_pkg;

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [7:0] OFS_DATA_LATCH    = 8'h4d;
   localparam logic [7:0] OFS_SECTOR_TARGET = 8'h6a;
   localparam logic [7:0] OFS_SECTOR_COUNT  = 8'h6b;
   localparam logic [7:0] OFS_BRANCH_TARGET = 8'h6c;
   localparam logic [7:0] OFS_LENGTH_HIGH   = 8'h6d;
   localparam logic [7:0] OFS_LENGTH_LOW    = 8'h6e;
   localparam logic [7:0] OFS_REVISION      = 8'h6f;
   localparam logic [7:0] OFS_DIRECT_PORT   = 8'h70;

   // ***********************************************
   // field layouts and reset values
   // ***********************************************
   localparam int         BRANCH_W       = 5;
   localparam int         LENGTH_W       = 12;
   localparam int         LENGTH_HIGH_W  = 4;
   localparam int         POLARITY_BIT   = 0;
   localparam int         STATUS_POL_BIT = 3;
   localparam logic [7:0] RESET_BYTE     = 8'h00;
   localparam logic [7:0] LAST_COUNT     = 8'h00;
   localparam logic [7:0] REVISION_CODE  = 8'h01; // arbitrary value
   localparam logic [15:0] POINTER_STEP  = 16'h0001;

   // ***********************************************
   // microcontroller access carrier
   // ***********************************************
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dss_access_t;

   // ***********************************************
   // sequencer event carrier
   // ***********************************************
   typedef struct packed {
      logic eccStart;
      logic eccDone;
      logic sectorEnd;
      logic branchCond;
   } dss_seq_event_t;

endpackage : dss_pkg

/* dss_polarity.sv */
// applies host polarity select to host reset and interrupt lines
module dss_polarity
(
   input  wire logic polaritySelect,
   input  wire logic hostResetPin,
   input  wire logic hostIrqInternal,
   output logic      hostResetActive,
   output logic      host_interrupt_line
);

   // ***********************************************
   // polarity mapping: set = drive-cable, clear = card
   // ***********************************************
   always_comb
   begin
      hostResetActive     = polaritySelect ? !hostResetPin : hostResetPin;
      host_interrupt_line = polaritySelect ? hostIrqInternal
                                           : !hostIrqInternal;
   end

endmodule : dss_polarity

/* dss_sector_regs.sv */
module dss_sector_regs
#(
   parameter logic [7:0] REVISION = dss_pkg::REVISION_CODE
)
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire dss_pkg::dss_access_t   acc,
   output logic [7:0]                  rdata,
   output logic                        rdataValid,
   input  wire dss_pkg::dss_seq_event_t seqEvent,
   input  wire logic [7:0]             idFromDisk,
   output logic                        idMatch,
   output logic                        lastSector,
   output logic                        seqHalt,
   output logic                        branchTake,
   output logic [4:0]                  branchAddr,
   input  wire logic                   chipResetBit,
   input  wire logic                   hostResetPin,
   input  wire logic                   hostIrqInternal,
   output logic                        hostResetActive,
   output logic                        host_interrupt_line,
   output logic                        host_polarity_select,
   input  wire logic                   autoIncEnable,
   input  wire logic                   outputEnableDisable,
   input  wire logic [7:0]             bufDataIn,
   output logic [7:0]                  bufDataOut,
   output logic                        bufDataOe,
   output logic                        bufWrite,
   output logic                        bufRead,
   output logic                        buffer_output_enable_n,
   output logic [15:0]                 bufAddr,
   input  wire logic                   pointerLoad,
   input  wire logic [15:0]            pointerLoadValue,
   output logic [15:0]                 disk_buffer_pointer,
   output logic [7:0]                  dataLatch,
   output logic [7:0]                  sectorTarget,
   output logic [7:0]                  sectorCount,
   output logic [11:0]                 fieldLength
);

   // ***********************************************
   // storage
   // ***********************************************
   logic [7:0]  bufSync1;
   logic [7:0]  bufSync2;
   logic        resetSync1;
   logic        resetSync2;
   logic [4:0]  branchTarget;
   logic        portHit;
   logic        pointerStep;
   logic        latchLoad;
   logic        lastArmed;
   logic [7:0]  next_rdata;

   // write strobe for one offset
   function automatic logic wrHit(input dss_pkg::dss_access_t a,
                                  input logic [7:0] ofs);
      wrHit = a.wr && (a.addr == ofs);
   endfunction : wrHit

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      bufSync1   <= bufDataIn;
      bufSync2   <= bufSync1;
      resetSync1 <= hostResetPin;
      resetSync2 <= resetSync1;
   end

   // ***********************************************
   // direct buffer port
   // ***********************************************
   dss_direct_port u_port
   (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .acc                    (acc),
      .autoIncEnable          (autoIncEnable),
      .outputEnableDisable    (outputEnableDisable),
      .bufDataIn              (bufSync2),
      .pointerIn              (disk_buffer_pointer),
      .portHit                (portHit),
      .pointerStep            (pointerStep),
      .bufDataOut             (bufDataOut),
      .bufDataOe              (bufDataOe),
      .bufWrite               (bufWrite),
      .bufRead                (bufRead),
      .buffer_output_enable_n (buffer_output_enable_n),
      .bufAddr                (bufAddr),
      .latchLoad              (latchLoad)
   );

   // ***********************************************
   // host polarity
   // ***********************************************
   dss_polarity u_pol
   (
      .polaritySelect      (host_polarity_select),
      .hostResetPin        (resetSync2),
      .hostIrqInternal     (hostIrqInternal),
      .hostResetActive     (hostResetActive),
      .host_interrupt_line (host_interrupt_line)
   );

   // ***********************************************
   // sector target
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         sectorTarget <= dss_pkg::RESET_BYTE;
      else if (wrHit(acc, dss_pkg::OFS_SECTOR_TARGET))
         sectorTarget <= acc.wdata;
      else if (seqEvent.eccDone)
         sectorTarget <= sectorTarget + 8'h01;
   end

   // id search compare
   assign idMatch = (idFromDisk == sectorTarget);

   // ***********************************************
   // sector count
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         sectorCount <= dss_pkg::RESET_BYTE;
      else if (wrHit(acc, dss_pkg::OFS_SECTOR_COUNT))
         sectorCount <= acc.wdata;
      else if (seqEvent.eccStart)
         sectorCount <= sectorCount - 8'h01;
   end

   // last sector detect and halt
   assign lastSector = (sectorCount == dss_pkg::LAST_COUNT)
                       && seqEvent.branchCond;

   always_ff @(posedge clk_sys)
   begin
      if (rst || chipResetBit)
         lastArmed <= 1'b0;
      else if (lastSector)
         lastArmed <= 1'b1;
      else if (seqEvent.sectorEnd)
         lastArmed <= 1'b0;
   end

   // halt pulse at end of final sector
   assign seqHalt = seqEvent.sectorEnd && (lastArmed || lastSector);

   // ***********************************************
   // branch target
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst || chipResetBit)
         branchTarget <= '0;
      else if (wrHit(acc, dss_pkg::OFS_BRANCH_TARGET))
         branchTarget <= acc.wdata[dss_pkg::BRANCH_W-1:0];
   end

   assign branchAddr = branchTarget;
   assign branchTake = seqEvent.branchCond;

   // ***********************************************
   // field length register
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         fieldLength <= '0;
      else
      begin
         if (wrHit(acc, dss_pkg::OFS_LENGTH_HIGH))
            fieldLength[11:8] <= acc.wdata[dss_pkg::LENGTH_HIGH_W-1:0];
         if (wrHit(acc, dss_pkg::OFS_LENGTH_LOW))
            fieldLength[7:0] <= acc.wdata;
      end
   end

   // ***********************************************
   // polarity control (write side of 6fh)
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         host_polarity_select <= 1'b0;
      else if (wrHit(acc, dss_pkg::OFS_REVISION))
         host_polarity_select <= acc.wdata[dss_pkg::POLARITY_BIT];
   end

   // ***********************************************
   // disk buffer pointer
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         disk_buffer_pointer <= '0;
      else if (pointerLoad)
         disk_buffer_pointer <= pointerLoadValue;
      else if (pointerStep)
         disk_buffer_pointer <= disk_buffer_pointer
                                + dss_pkg::POINTER_STEP;
   end

   // ***********************************************
   // data latch capture
   // ***********************************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         dataLatch <= dss_pkg::RESET_BYTE;
      else if (latchLoad)
         dataLatch <= bufSync2;
   end

   // ***********************************************
   // read mux
   // ***********************************************
   always_comb
   begin
      next_rdata = 8'h00;
      case (acc.addr)
         dss_pkg::OFS_SECTOR_TARGET: next_rdata = sectorTarget;
         dss_pkg::OFS_SECTOR_COUNT:  next_rdata = sectorCount;
         dss_pkg::OFS_BRANCH_TARGET: next_rdata = {3'h0, branchTarget};
         dss_pkg::OFS_LENGTH_HIGH:   next_rdata = {4'h0, fieldLength[11:8]};
         dss_pkg::OFS_LENGTH_LOW:    next_rdata = fieldLength[7:0];
         dss_pkg::OFS_REVISION:      next_rdata = REVISION;
         dss_pkg::OFS_DIRECT_PORT:   next_rdata = bufSync2;
         dss_pkg::OFS_DATA_LATCH:    next_rdata = dataLatch;
         default:                    next_rdata = 8'h00;
      endcase
   end

   // registered read data, one cycle after rd
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rdata      <= 8'h00;
         rdataValid <= 1'b0;
      end
      else
      begin
         rdataValid <= acc.rd;
         if (acc.rd)
            rdata <= next_rdata;
      end
   end

endmodule : dss_sector_regs

/* dss_sector_regs_sva.sv */
module dss_sector_regs_sva
#(
   parameter logic [7:0] REVISION = dss_pkg::REVISION_CODE
)
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire dss_pkg::dss_access_t    acc,
   input  wire logic [7:0]              rdata,
   input  wire logic                    rdataValid,
   input  wire dss_pkg::dss_seq_event_t seqEvent,
   input  wire logic [7:0]              idFromDisk,
   input  wire logic                    idMatch,
   input  wire logic                    lastSector,
   input  wire logic                    seqHalt,
   input  wire logic [4:0]              branchAddr,
   input  wire logic                    chipResetBit,
   input  wire logic                    hostIrqInternal,
   input  wire logic                    host_interrupt_line,
   input  wire logic                    host_polarity_select,
   input  wire logic                    autoIncEnable,
   input  wire logic                    outputEnableDisable,
   input  wire logic                    pointerLoad,
   input  wire logic                    bufRead,
   input  wire logic                    bufWrite,
   input  wire logic                    bufDataOe,
   input  wire logic [7:0]              bufDataOut,
   input  wire logic                    buffer_output_enable_n,
   input  wire logic [15:0]             disk_buffer_pointer,
   input  wire logic [7:0]              dataLatch,
   input  wire logic [7:0]              sectorTarget,
   input  wire logic [7:0]              sectorCount,
   input  wire logic [11:0]             fieldLength
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ***********************************************
   // register and port relations
   // ***********************************************
   id_match_a: assert property (idMatch == (idFromDisk == sectorTarget))
      else $error("id match wrong");
   target_inc_a: assert property (seqEvent.eccDone && !acc.wr
      |=> sectorTarget == $past(sectorTarget) + 8'h01)
      else $error("target not advanced");
   count_dec_a: assert property (seqEvent.eccStart && !acc.wr
      && sectorCount != 8'h00 |=> sectorCount == $past(sectorCount) - 8'h01)
      else $error("count not lowered");
   halt_last_a: assert property (seqEvent.sectorEnd && !chipResetBit
      && seqEvent.branchCond && sectorCount == 8'h00 |-> seqHalt && lastSector)
      else $error("no halt on last sector");
   branch_clear_a: assert property (chipResetBit && !acc.wr
      |=> branchAddr == 5'h00) else $error("branch not cleared");
   reset_clear_a: assert property (disable iff (1'b0) rst |=>
      sectorTarget == 8'h00 && sectorCount == 8'h00 && branchAddr == 5'h00
      && fieldLength == 12'h000) else $error("reset left a register");
   rev_read_a: assert property (acc.rd && acc.addr == 8'h6f
      |=> rdataValid && rdata == REVISION) else $error("revision wrong");
   irq_pol_a: assert property (host_interrupt_line ==
      (host_polarity_select ? hostIrqInternal : !hostIrqInternal))
      else $error("interrupt polarity wrong");
   port_read_a: assert property (acc.rd && acc.addr == 8'h70
      |-> bufRead && buffer_output_enable_n == outputEnableDisable)
      else $error("port read decode wrong");
   port_write_a: assert property (acc.wr && acc.addr == 8'h70
      |-> bufWrite && bufDataOe && bufDataOut == acc.wdata)
      else $error("port write decode wrong");
   latch_load_a: assert property (acc.rd && acc.addr == 8'h70
      |=> dataLatch == rdata) else $error("latch not loaded");
   ptr_step_a: assert property ((acc.rd || acc.wr) && acc.addr == 8'h70
      && autoIncEnable && !pointerLoad
      |=> disk_buffer_pointer == $past(disk_buffer_pointer) + 16'h0001)
      else $error("pointer not advanced");
endmodule : dss_sector_regs_sva

bind dss_sector_regs dss_sector_regs_sva #(.REVISION(REVISION)) chk (
   .clk_sys, .rst, .acc, .rdata, .rdataValid, .seqEvent, .idFromDisk,
   .idMatch, .lastSector, .seqHalt, .branchAddr, .chipResetBit,
   .hostIrqInternal, .host_interrupt_line, .host_polarity_select,
   .autoIncEnable, .outputEnableDisable, .pointerLoad, .bufRead,
   .bufWrite, .bufDataOe, .bufDataOut,
   .buffer_output_enable_n, .disk_buffer_pointer, .dataLatch,
   .sectorTarget, .sectorCount, .fieldLength);

/* dss_sector_regs_tb.sv */
module dss_sector_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {logic [7:0] a; logic [7:0] d;
                          logic [7:0] e;} dss_row_t;
   logic clk_sys, rst, rdataValid, idMatch, lastSector, seqHalt, branchTake;
   logic chipResetBit, hostResetPin, hostIrqInternal, hostResetActive;
   logic host_interrupt_line, host_polarity_select, autoIncEnable;
   logic outputEnableDisable, bufDataOe, bufWrite, bufRead, pointerLoad;
   logic buffer_output_enable_n, v;
   logic [7:0] rdata, idFromDisk, bufDataIn, bufDataOut, dataLatch, d;
   logic [7:0] sectorTarget, sectorCount;
   logic [4:0] branchAddr;
   logic [11:0] fieldLength;
   logic [15:0] bufAddr, pointerLoadValue, disk_buffer_pointer;
   dss_pkg::dss_access_t acc;
   dss_pkg::dss_seq_event_t seqEvent;
   int error_cnt, checks_done;
   dss_row_t rows [7] = '{'{8'h6a, 8'ha5, 8'ha5}, '{8'h6b, 8'h3c, 8'h3c},
      '{8'h6c, 8'hff, 8'h1f}, '{8'h6d, 8'hff, 8'h0f}, '{8'h6e, 8'h5a, 8'h5a},
      '{8'h6f, 8'hff, dss_pkg::REVISION_CODE}, '{8'h10, 8'h77, 8'h00}};

   dss_sector_regs dut (.clk_sys, .rst, .acc, .rdata, .rdataValid, .seqEvent,
      .idFromDisk, .idMatch, .lastSector, .seqHalt, .branchTake, .branchAddr,
      .chipResetBit, .hostResetPin, .hostIrqInternal, .hostResetActive,
      .host_interrupt_line, .host_polarity_select, .autoIncEnable,
      .outputEnableDisable, .bufDataIn, .bufDataOut, .bufDataOe, .bufWrite,
      .bufRead, .buffer_output_enable_n, .bufAddr, .pointerLoad,
      .pointerLoadValue, .disk_buffer_pointer, .dataLatch, .sectorTarget,
      .sectorCount, .fieldLength);
   dss_mcu_model mcu (.clk_sys, .rdata, .rdataValid, .acc);

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // one sequencer event for a cycle, then a quiet cycle
   task automatic ev(input logic [3:0] e);
      seqEvent = e;
      @(posedge clk_sys);
      #1 seqEvent = 4'h0;
      @(posedge clk_sys);
      #1;
   endtask : ev

   task automatic zchk(input string n);
      chk({n, " target"}, 16'h0000, {8'h00, sectorTarget});
      chk({n, " count"}, 16'h0000, {8'h00, sectorCount});
      chk({n, " branch"}, 16'h0000, {11'h000, branchAddr});
      chk({n, " length"}, 16'h0000, {4'h0, fieldLength});
      $display("test done: %s", n);
   endtask : zchk

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // watchdog on the whole run
   initial
   begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      summarize();
   end

   // ***********************************************
   // main sequence
   // ***********************************************
   initial
   begin
      {rst, chipResetBit, hostResetPin, hostIrqInternal} = 4'b1001;
      {autoIncEnable, outputEnableDisable, pointerLoad} = 3'b000;
      {idFromDisk, bufDataIn, pointerLoadValue} = 32'h0;
      seqEvent = 4'h0;
      repeat (12) @(posedge clk_sys);
      #1 rst = 1'b0;
      zchk("reset");
      // register rows: write, read back masked value
      foreach (rows[i])
      begin
         mcu.wr(rows[i].a, rows[i].d);
         mcu.rd(rows[i].a, d, v);
         chk("row read", 16'(rows[i].e), 16'(d));
         chk("row valid", 16'h0001, {15'h0000, v});
      end
      chk("length", 16'h0f5a, {4'h0, fieldLength});
      chk("polarity", 16'h0001, {15'h0000, host_polarity_select});
      chk("irq set", 16'h0001, {15'h0000, host_interrupt_line});
      chk("rst low act", 16'h0001, {15'h0000, hostResetActive});
      mcu.wr(8'h6f, 8'hfe);
      chk("irq clear", 16'h0000, {15'h0000, host_interrupt_line});
      chk("rst high act", 16'h0000, {15'h0000, hostResetActive});
      $display("test done: rows");
      // multi-sector run set up first, sequencer idle around port use
      mcu.wr(8'h6b, 8'h02);
      mcu.wr(8'h6a, 8'h10);
      ev(4'b1000);
      chk("count dec", 16'h0001, {8'h00, sectorCount});
      ev(4'b0100);
      chk("target inc", 16'h0011, {8'h00, sectorTarget});
      chk("id miss", 16'h0000, {15'h0000, idMatch});
      idFromDisk = 8'h11;
      ev(4'b1000);
      chk("id match", 16'h0001, {15'h0000, idMatch});
      seqEvent = 4'b0011;
      #1 chk("last", 16'h0001, {15'h0000, lastSector});
      chk("halt", 16'h0001, {15'h0000, seqHalt});
      chk("branch take", 16'h0001, {15'h0000, branchTake});
      @(posedge clk_sys);
      #1 seqEvent = 4'h0;
      chipResetBit = 1'b1;
      @(posedge clk_sys);
      #1 chipResetBit = 1'b0;
      chk("branch clr", 16'h0000, {11'h000, branchAddr});
      $display("test done: sequencer");
      // direct port: buffer read, latch, switch read, write, pointer
      {autoIncEnable, pointerLoad, bufDataIn} = {2'b11, 8'hc3};
      pointerLoadValue = 16'h0100;
      @(posedge clk_sys);
      #1 pointerLoad = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 mcu.rd(8'h70, d, v);
      chk("port read", 16'h00c3, {8'h00, d});
      chk("latch", 16'h00c3, {8'h00, dataLatch});
      chk("ptr inc", 16'h0101, disk_buffer_pointer);
      mcu.rd(8'h4d, d, v);
      chk("latch read", 16'h00c3, {8'h00, d});
      {outputEnableDisable, bufDataIn} = {1'b1, 8'h3c};
      repeat (3) @(posedge clk_sys);
      #1 mcu.rd(8'h70, d, v);
      chk("switch read", 16'h003c, {8'h00, d});
      autoIncEnable = 1'b0;
      mcu.wr(8'h70, 8'h96);
      chk("ptr hold", 16'h0102, disk_buffer_pointer);
      chk("buf addr", 16'h0102, bufAddr);
      $display("test done: direct port");
      // second reset in mid-run, count and branch loaded first
      mcu.wr(8'h6b, 8'h07);
      mcu.wr(8'h6c, 8'h09);
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 rst = 1'b0;
      zchk("mid reset");
      summarize();
   end
endmodule : dss_sector_regs_tb
